// ==== hw/tcoc_channel.sv ====
// timer channel 1 in output compare mode: registers, input selection, trigger path
`timescale 1ns/1ps
`include "tcoc_defines.svh"
module tcoc_channel
  import tcoc_pkg::*;
#(
  parameter int CNT_W    = 16,
  parameter int TRIG_DLY = `TCOC_TRIG_DLY
) (
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  input  wire logic [`TCOC_ADDR_W-1:0] i_addr,
  input  wire logic [`TCOC_DATA_W-1:0] i_wdata,
  input  wire logic                    i_wr_stb,
  input  wire logic                    i_rd_stb,
  output logic      [`TCOC_DATA_W-1:0] o_rdata,
  input  wire logic [CNT_W-1:0]        i_counter_value,
  input  wire logic                    i_update_evt,
  input  wire logic                    i_trig_evt,
  input  wire logic [1:0]              i_protect_level,
  input  wire logic                    i_timer_input_one,
  input  wire logic                    i_timer_input_two,
  input  wire logic                    i_internal_trigger_selection_out,
  output logic                         o_chan1_reference_level,
  output logic                         o_chan1_compare_out,
  output logic                         o_chan1_capture_source,
  output logic                         o_chan1_is_input,
  output logic                         o_chan1_match_pulse
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int NPIN = 2;

  tcoc_dir_t               dir_ff;
  logic                    fast_ff;
  logic                    pre_en_ff;
  tcoc_mode_t              mode_ff;
  logic                    outen_ff;
  logic [`TCOC_DATA_W-1:0] rdata_ff;
  logic [`TCOC_DATA_W-1:0] nxt_rdata;
  logic                    match_prev_ff;
  logic [TRIG_DLY-1:0]     trig_pipe_ff;
  logic [NPIN-1:0]         pin_s1_ff;
  logic [NPIN-1:0]         pin_s2_ff;
  logic [NPIN-1:0]         pin_s3_ff;
  logic [NPIN-1:0]         pin_lvl_ff;
  logic [NPIN-1:0]         pin_raw;
  logic                    src_ff;
  logic                    nxt_src;
  logic                    ref_lvl;
  logic                    cmp_match;
  logic                    cmp_below;
  logic                    cmp_above;
  logic [CNT_W-1:0]        cmp_preload;
  logic [CNT_W-1:0]        cmp_active;
  logic                    wr_mode;
  logic                    wr_enable;
  logic                    wr_cmp;
  logic                    cfg_lock;
  logic                    match_evt;
  logic                    trig_act;
  logic                    sel_mode;
  logic                    sel_enable;
  logic                    sel_cmp;
  logic                    sel_status;
  logic                    sel_active;
  logic [`TCOC_DATA_W-1:0] mode_word;
  logic [`TCOC_DATA_W-1:0] status_word;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic reg_hit(input logic [`TCOC_ADDR_W-1:0] addr,
                                   input logic [`TCOC_ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  assign sel_mode   = reg_hit(i_addr, `TCOC_OFS_MODE);
  assign sel_enable = reg_hit(i_addr, `TCOC_OFS_ENABLE);
  assign sel_cmp    = reg_hit(i_addr, `TCOC_OFS_CMP);
  assign sel_status = reg_hit(i_addr, `TCOC_OFS_STATUS);
  assign sel_active = reg_hit(i_addr, `TCOC_OFS_ACTIVE);

  assign wr_mode   = i_wr_stb && sel_mode;
  assign wr_enable = i_wr_stb && sel_enable;
  assign wr_cmp    = i_wr_stb && sel_cmp;

  // preload and mode freeze once protection reaches its top level on an output channel
  assign cfg_lock = (i_protect_level == `TCOC_PROT_LOCK) && (dir_ff == TCOC_DIR_OUT);

  ////////////////////////////////////////////////////////////////////////////////
  // mode register fields

  // direction may only move while the channel is disabled; the write is dropped silently
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_ff <= tcoc_dir_t'(`TCOC_RST_DIR);
    end else if (wr_mode && !outen_ff) begin
      dir_ff <= tcoc_dir_t'(i_wdata[`TCOC_DIR_MSB:`TCOC_DIR_LSB]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fast_ff <= 1'b0;
    end else if (wr_mode) begin
      fast_ff <= i_wdata[`TCOC_FAST_BIT];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_en_ff <= 1'b0;
    end else if (wr_mode && !cfg_lock) begin
      pre_en_ff <= i_wdata[`TCOC_PRE_BIT];
    end
  end

  // software is expected to keep PWM without preload to single-pulse use only
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_ff <= tcoc_mode_t'(`TCOC_RST_MODE);
    end else if (wr_mode && !cfg_lock) begin
      mode_ff <= tcoc_mode_t'(i_wdata[`TCOC_MODE_MSB:`TCOC_MODE_LSB]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel enable register

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      outen_ff <= 1'b0;
    end else if (wr_enable) begin
      outen_ff <= i_wdata[`TCOC_OUTEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare value and comparison

  tcoc_cmp_stage #(
    .W (CNT_W)
  ) u_cmp (
    .i_mclk          (i_mclk),
    .i_rst_n         (i_rst_n),
    .i_wr            (wr_cmp),
    .i_wdata         (i_wdata[CNT_W-1:0]),
    .i_preload_en    (pre_en_ff),
    .i_update_evt    (i_update_evt),
    .i_counter_value (i_counter_value),
    .o_preload       (cmp_preload),
    .o_active        (cmp_active),
    .o_match         (cmp_match),
    .o_below         (cmp_below),
    .o_above         (cmp_above)
  );

  // a held counter would otherwise toggle every clock; only the first equal cycle counts
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      match_prev_ff <= 1'b0;
    end else begin
      match_prev_ff <= cmp_match;
    end
  end

  assign match_evt = cmp_match && !match_prev_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // trigger path

  // the normal path waits TRIG_DLY clocks; fast enable bypasses the pipe entirely
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trig_pipe_ff <= '0;
    end else begin
      trig_pipe_ff[0] <= i_trig_evt;
      for (int i = 1; i < TRIG_DLY; i++) begin
        trig_pipe_ff[i] <= trig_pipe_ff[i-1];
      end
    end
  end

  assign trig_act = fast_ff ? i_trig_evt : trig_pipe_ff[TRIG_DLY-1];

  ////////////////////////////////////////////////////////////////////////////////
  // reference level

  tcoc_ref_gen u_ref (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_mode      (mode_ff),
    .i_match_evt (match_evt),
    .i_force_evt (trig_act),
    .i_below     (cmp_below),
    .i_above     (cmp_above),
    .o_ref       (ref_lvl)
  );

  assign o_chan1_reference_level = ref_lvl;
  assign o_chan1_match_pulse     = match_evt;

  ////////////////////////////////////////////////////////////////////////////////
  // compare output pin

  // the pin output follows the reference only when enabled on an output channel
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_chan1_compare_out <= 1'b0;
    end else begin
      o_chan1_compare_out <= ref_lvl && outen_ff && (dir_ff == TCOC_DIR_OUT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timer input pins: three flops, a change is taken once stages two and three agree

  assign pin_raw = {i_timer_input_two, i_timer_input_one};

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_lvl_ff <= '0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) begin
          pin_lvl_ff[i] <= pin_s3_ff[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture source selection

  // the internal trigger output is already on this clock, so it needs no synchroniser
  always_comb begin
    nxt_src = 1'b0;
    unique case (dir_ff)
      TCOC_DIR_OUT: nxt_src = 1'b0;
      TCOC_DIR_TI1: nxt_src = pin_lvl_ff[0];
      TCOC_DIR_TI2: nxt_src = pin_lvl_ff[1];
      TCOC_DIR_TRC: nxt_src = i_internal_trigger_selection_out;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_ff <= 1'b0;
    end else begin
      src_ff <= nxt_src;
    end
  end

  assign o_chan1_capture_source = src_ff;
  assign o_chan1_is_input       = (dir_ff != TCOC_DIR_OUT);

  ////////////////////////////////////////////////////////////////////////////////
  // readable words

  // bits above the mode field stay zero
  always_comb begin
    mode_word                                = '0;
    mode_word[`TCOC_DIR_MSB:`TCOC_DIR_LSB]   = dir_ff;
    mode_word[`TCOC_FAST_BIT]                = fast_ff;
    mode_word[`TCOC_PRE_BIT]                 = pre_en_ff;
    mode_word[`TCOC_MODE_MSB:`TCOC_MODE_LSB] = mode_ff;
  end

  // status bits are live; a read clears nothing
  always_comb begin
    status_word                     = '0;
    status_word[`TCOC_ST_REF_BIT]   = ref_lvl;
    status_word[`TCOC_ST_MATCH_BIT] = cmp_match;
    status_word[`TCOC_ST_SRC_BIT]   = src_ff;
    status_word[`TCOC_ST_LOCK_BIT]  = cfg_lock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    nxt_rdata = '0;
    if (sel_mode) begin
      nxt_rdata = mode_word;
    end else if (sel_enable) begin
      nxt_rdata[`TCOC_OUTEN_BIT] = outen_ff;
    end else if (sel_cmp) begin
      nxt_rdata[CNT_W-1:0] = cmp_preload;
    end else if (sel_status) begin
      nxt_rdata = status_word;
    end else if (sel_active) begin
      nxt_rdata[CNT_W-1:0] = cmp_active;
    end
  end

  // data stands only in the cycle after the strobe; otherwise the bus reads zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= `TCOC_RST_DATA;
    end else if (i_rd_stb) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= `TCOC_RST_DATA;
    end
  end

  assign o_rdata = rdata_ff;

endmodule : tcoc_channel

// ==== include/tcoc_defines.svh ====
// register map, field positions, reset values and timing counts of the compare channel
`ifndef TCOC_DEFINES_SVH
`define TCOC_DEFINES_SVH

`define TCOC_ADDR_W       8
`define TCOC_DATA_W       16
`define TCOC_OFS_MODE     8'h18
`define TCOC_OFS_ENABLE   8'h20
`define TCOC_OFS_CMP      8'h34
`define TCOC_OFS_STATUS   8'h38
`define TCOC_OFS_ACTIVE   8'h3C

`define TCOC_DIR_LSB      0
`define TCOC_DIR_MSB      1
`define TCOC_FAST_BIT     2
`define TCOC_PRE_BIT      3
`define TCOC_MODE_LSB     4
`define TCOC_MODE_MSB     6
`define TCOC_OUTEN_BIT    0

`define TCOC_ST_REF_BIT   0
`define TCOC_ST_MATCH_BIT 1
`define TCOC_ST_SRC_BIT   2
`define TCOC_ST_LOCK_BIT  3

`define TCOC_RST_DIR      2'h0
`define TCOC_RST_MODE     3'h0
`define TCOC_RST_DATA     16'h0000
`define TCOC_PROT_LOCK    2'h3

// normal trigger-to-output path length in timer clocks; the fast path takes none
`define TCOC_TRIG_DLY     2

`endif

// ==== include/tcoc_pkg.sv ====
// types shared by the compare channel modules
package tcoc_pkg;

  typedef enum logic [2:0] {
    TCOC_FREEZE    = 3'h0,
    TCOC_SET_MATCH = 3'h1,
    TCOC_CLR_MATCH = 3'h2,
    TCOC_TOG_MATCH = 3'h3,
    TCOC_FORCE_LO  = 3'h4,
    TCOC_FORCE_HI  = 3'h5,
    TCOC_PWM1      = 3'h6,
    TCOC_PWM2      = 3'h7
  } tcoc_mode_t;

  typedef enum logic [1:0] {
    TCOC_DIR_OUT = 2'h0,
    TCOC_DIR_TI1 = 2'h1,
    TCOC_DIR_TI2 = 2'h2,
    TCOC_DIR_TRC = 2'h3
  } tcoc_dir_t;

endpackage : tcoc_pkg

// ==== hw/tcoc_cmp_stage.sv ====
// compare value preload stage, active compare value and counter comparison
`timescale 1ns/1ps
`include "tcoc_defines.svh"
module tcoc_cmp_stage
  import tcoc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_wr,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic         i_preload_en,
  input  wire logic         i_update_evt,
  input  wire logic [W-1:0] i_counter_value,
  output logic      [W-1:0] o_preload,
  output logic      [W-1:0] o_active,
  output logic              o_match,
  output logic              o_below,
  output logic              o_above
);

  logic [W-1:0] preload_ff;
  logic [W-1:0] active_ff;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      preload_ff <= W'(`TCOC_RST_DATA);
    end else if (i_wr) begin
      preload_ff <= i_wdata;
    end
  end

  // without preload a write lands in the active value at once; with it, only an update moves it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_ff <= W'(`TCOC_RST_DATA);
    end else if (i_wr && !i_preload_en) begin
      active_ff <= i_wdata;
    end else if (i_update_evt && i_preload_en) begin
      active_ff <= preload_ff;
    end
  end

  assign o_preload = preload_ff;
  assign o_active  = active_ff;
  assign o_match   = (i_counter_value == active_ff);
  assign o_below   = (i_counter_value < active_ff);
  assign o_above   = (i_counter_value > active_ff);

endmodule : tcoc_cmp_stage

// ==== hw/tcoc_ref_gen.sv ====
// reference level generator for the eight compare modes
`timescale 1ns/1ps
module tcoc_ref_gen
  import tcoc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  tcoc_mode_t      i_mode,
  input  wire logic       i_match_evt,
  input  wire logic       i_force_evt,
  input  wire logic       i_below,
  input  wire logic       i_above,
  output logic            o_ref
);

  logic       ref_ff;
  logic       nxt_ref;
  logic       lvl_ff;
  logic       lvl;
  logic       hit;
  tcoc_mode_t prev_mode_ff;

  assign lvl = (i_mode == TCOC_PWM2) ? i_above : i_below;
  assign hit = i_match_evt | i_force_evt;

  always_comb begin
    nxt_ref = ref_ff;
    unique case (i_mode)
      TCOC_FREEZE:    nxt_ref = ref_ff;
      TCOC_SET_MATCH: if (hit) nxt_ref = 1'b1;
      TCOC_CLR_MATCH: if (hit) nxt_ref = 1'b0;
      TCOC_TOG_MATCH: if (hit) nxt_ref = ~ref_ff;
      TCOC_FORCE_LO:  nxt_ref = 1'b0;
      TCOC_FORCE_HI:  nxt_ref = 1'b1;
      TCOC_PWM1, TCOC_PWM2: begin
        // a trigger jumps straight to the level that follows the compare
        if (i_force_evt) begin
          nxt_ref = (i_mode == TCOC_PWM2);
        end else if (lvl != lvl_ff || prev_mode_ff == TCOC_FREEZE) begin
          nxt_ref = lvl;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_ff       <= 1'b0;
      lvl_ff       <= 1'b0;
      prev_mode_ff <= TCOC_FREEZE;
    end else begin
      ref_ff       <= nxt_ref;
      lvl_ff       <= lvl;
      prev_mode_ff <= i_mode;
    end
  end

  assign o_ref = ref_ff;

endmodule : tcoc_ref_gen

// ==== tb/tcoc_channel_checker.sv ====
// port-level assertions for the compare channel
`timescale 1ns/1ps
`include "tcoc_defines.svh"
module tcoc_channel_checker
  import tcoc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic                    i_mclk,
  input wire logic                    i_rst_n,
  input wire logic [`TCOC_ADDR_W-1:0] i_addr,
  input wire logic [`TCOC_DATA_W-1:0] i_wdata,
  input wire logic                    i_wr_stb,
  input wire logic                    i_rd_stb,
  input wire logic [`TCOC_DATA_W-1:0] o_rdata,
  input wire logic [1:0]              i_protect_level,
  input wire logic                    o_chan1_reference_level,
  input wire logic                    o_chan1_compare_out,
  input wire logic                    o_chan1_capture_source,
  input wire logic                    o_chan1_is_input,
  input wire logic                    o_chan1_match_pulse
);
  logic       en_ff;
  logic [6:0] md_ff;
  logic       lock;
  // shadow of the mode register, with the same refusals the device applies
  assign lock = (i_protect_level == `TCOC_PROT_LOCK) && (md_ff[1:0] == 2'h0);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_ff <= 1'b0;
      md_ff <= 7'h00;
    end else if (i_wr_stb && i_addr == `TCOC_OFS_ENABLE) begin
      en_ff <= i_wdata[0];
    end else if (i_wr_stb && i_addr == `TCOC_OFS_MODE) begin
      md_ff[2] <= i_wdata[2];
      if (!en_ff) begin
        md_ff[1:0] <= i_wdata[1:0];
      end
      if (!lock) begin
        md_ff[3]   <= i_wdata[3];
        md_ff[6:4] <= i_wdata[6:4];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_rdata_idle: assert property (!$past(i_rd_stb) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_mode_readback: assert property ($past(i_rd_stb) && $past(i_addr) == `TCOC_OFS_MODE
    |-> o_rdata == {9'h000, $past(md_ff)}) else $error("mode register readback wrong");
  a_dir_input: assert property (o_chan1_is_input == (md_ff[1:0] != 2'h0))
    else $error("input flag disagrees with direction");
  a_out_gating: assert property (o_chan1_compare_out == ($past(o_chan1_reference_level)
    && $past(en_ff) && !$past(o_chan1_is_input))) else $error("compare output gating wrong");
  a_capture_idle: assert property (!o_chan1_is_input |=> !o_chan1_capture_source)
    else $error("capture source active while output");
  a_force_low: assert property (md_ff[6:4] == TCOC_FORCE_LO |=> !o_chan1_reference_level)
    else $error("forced low not low");
  a_force_high: assert property (md_ff[6:4] == TCOC_FORCE_HI |=> o_chan1_reference_level)
    else $error("forced high not high");
  a_freeze_hold: assert property (md_ff[6:4] == TCOC_FREEZE && $past(md_ff[6:4]) == TCOC_FREEZE
    |=> $stable(o_chan1_reference_level)) else $error("reference moved in freeze");
  a_set_match: assert property (md_ff[6:4] == TCOC_SET_MATCH && o_chan1_match_pulse
    |=> o_chan1_reference_level) else $error("match did not set reference");
  a_clr_match: assert property (md_ff[6:4] == TCOC_CLR_MATCH && o_chan1_match_pulse
    |=> !o_chan1_reference_level) else $error("match did not clear reference");
  a_tog_match: assert property (md_ff[6:4] == TCOC_TOG_MATCH && o_chan1_match_pulse
    |=> o_chan1_reference_level != $past(o_chan1_reference_level)) else $error("match did not toggle");
  c_toggle: cover property (md_ff[6:4] == TCOC_TOG_MATCH && o_chan1_match_pulse);
  c_locked_write: cover property (i_wr_stb && i_addr == `TCOC_OFS_MODE && lock);
  c_input_dir: cover property (o_chan1_is_input && o_chan1_capture_source);
endmodule : tcoc_channel_checker

bind tcoc_channel tcoc_channel_checker #(.CNT_W(CNT_W)) i_tcoc_channel_checker (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr_stb(i_wr_stb),
  .i_rd_stb(i_rd_stb), .o_rdata(o_rdata), .i_protect_level(i_protect_level),
  .o_chan1_reference_level(o_chan1_reference_level), .o_chan1_compare_out(o_chan1_compare_out),
  .o_chan1_capture_source(o_chan1_capture_source), .o_chan1_is_input(o_chan1_is_input),
  .o_chan1_match_pulse(o_chan1_match_pulse)
);

// ==== tb/tcoc_timer_model.sv ====
// timer counter, update event and trigger source facing the compare channel
`timescale 1ns/1ps
module tcoc_timer_model #(
  parameter int CNT_W  = 16,
  parameter int PERIOD = 40
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_trig_req,
  output logic      [CNT_W-1:0] o_counter_value,
  output logic                  o_update_evt,
  output logic                  o_trig_evt
);
  // counter moves every clock; update pulse marks each wrap to zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_counter_value <= '0;
      o_update_evt    <= 1'b0;
    end else if (o_counter_value == CNT_W'(PERIOD - 1)) begin
      o_counter_value <= '0;
      o_update_evt    <= 1'b1;
    end else begin
      o_counter_value <= o_counter_value + 1'b1;
      o_update_evt    <= 1'b0;
    end
  end
  // one-clock trigger event, one cycle after the bench asks for it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_trig_evt <= 1'b0;
    end else begin
      o_trig_evt <= i_trig_req;
    end
  end
endmodule : tcoc_timer_model

// ==== tb/tcoc_channel_tb.sv ====
// self-checking bench for the compare channel
`timescale 1ns/1ps
`include "tcoc_defines.svh"
module tcoc_channel_tb;
  logic        i_mclk, i_rst_n, wr_stb, rd_stb, trig_req, ti1, ti2, internal_trigger_selection_out;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, cnt;
  logic [1:0]  protect;
  logic        upd, trig, ref_lvl, cmp_out, cap, is_in;
  int          failures, n_tests, n0, n1;

  tcoc_timer_model #(.CNT_W(16), .PERIOD(40)) i_tcoc_timer_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_trig_req(trig_req), .o_counter_value(cnt), .o_update_evt(upd), .o_trig_evt(trig));
  tcoc_channel #(.CNT_W(16)) i_tcoc_channel (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rdata(rdata), .i_counter_value(cnt),
    .i_update_evt(upd), .i_trig_evt(trig), .i_protect_level(protect), .i_timer_input_one(ti1),
    .i_timer_input_two(ti2), .i_internal_trigger_selection_out(internal_trigger_selection_out), .o_chan1_reference_level(ref_lvl),
    .o_chan1_compare_out(cmp_out), .o_chan1_capture_source(cap), .o_chan1_is_input(is_in),
    .o_chan1_match_pulse());
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge i_mclk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
    @(posedge i_mclk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge i_mclk);
    rd_stb <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : settle
  // waits for a counter value, then lets two edges pass so the reference has landed
  task automatic wait_cnt(input logic [15:0] v);
    int k;
    k = 0;
    #1;
    while (cnt !== v && k < 100) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    chk("counter wait", cnt, v);
    settle(2);
  endtask : wait_cnt
  task automatic trig_lat(output int n);
    @(posedge i_mclk);
    trig_req <= 1'b1;
    @(posedge i_mclk);
    trig_req <= 1'b0;
    #1;
    n = 0;
    while (ref_lvl !== 1'b1 && n < 20) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk("trigger level", ref_lvl, 16'h0001);
  endtask : trig_lat
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  initial begin
    {i_rst_n, wr_stb, rd_stb, trig_req, ti1, ti2, internal_trigger_selection_out} = 7'h00;
    addr = 8'h00;
    wdata = 16'h0000;
    protect = 2'h0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(`TCOC_OFS_MODE, `TCOC_RST_DATA, "mode reset");
    rd(`TCOC_OFS_ACTIVE, 16'h0000, "active reset");
    rd(8'h7E, 16'h0000, "unmapped read");
    wr(`TCOC_OFS_MODE, 16'hFFFF);
    rd(`TCOC_OFS_MODE, 16'h007F, "mode bits");
    $display("test registers done");
    // two input patterns so each pin direction gives a distinct answer; the internal trigger matches timer input one in both
    for (int b = 0; b < 2; b++) begin
      @(posedge i_mclk);
      ti1 <= ~b[0];
      ti2 <= b[0];
      internal_trigger_selection_out <= ~b[0];
      for (int d = 3; d >= 0; d--) begin
        wr(`TCOC_OFS_MODE, 16'(d));
        settle(6);
        chk("capture source", cap, (d == 0) ? 16'h0000 : 16'((d == 2) ? b : 1 - b));
        chk("is input", is_in, 16'(d != 0));
      end
    end
    $display("test direction done");
    wr(`TCOC_OFS_ENABLE, 16'h0001);
    wr(`TCOC_OFS_MODE, 16'h0001);
    rd(`TCOC_OFS_MODE, 16'h0000, "direction while enabled");
    wr(`TCOC_OFS_CMP, 16'h0014);
    rd(`TCOC_OFS_ACTIVE, 16'h0014, "direct compare");
    wr(`TCOC_OFS_MODE, 16'h0008);
    wr(`TCOC_OFS_CMP, 16'h001E);
    rd(`TCOC_OFS_ACTIVE, 16'h0014, "active before update");
    rd(`TCOC_OFS_CMP, 16'h001E, "preload stage");
    wait_cnt(16'h0000);
    rd(`TCOC_OFS_ACTIVE, 16'h001E, "active after update");
    wr(`TCOC_OFS_MODE, 16'h0040);
    wr(`TCOC_OFS_CMP, 16'h0014);
    settle(3);
    chk("forced low", ref_lvl, 16'h0000);
    wr(`TCOC_OFS_MODE, 16'h0050);
    settle(3);
    chk("forced high", ref_lvl, 16'h0001);
    chk("compare out", cmp_out, 16'h0001);
    @(posedge i_mclk);
    protect <= `TCOC_PROT_LOCK;
    wr(`TCOC_OFS_MODE, 16'h0048);
    rd(`TCOC_OFS_MODE, 16'h0050, "locked mode");
    @(posedge i_mclk);
    protect <= 2'h0;
    $display("test registers two done");
    wr(`TCOC_OFS_MODE, 16'h0020);
    wait_cnt(16'h0014);
    chk("clear on match", ref_lvl, 16'h0000);
    wr(`TCOC_OFS_MODE, 16'h0010);
    wait_cnt(16'h0014);
    chk("set on match", ref_lvl, 16'h0001);
    wr(`TCOC_OFS_MODE, 16'h0030);
    wait_cnt(16'h0014);
    chk("toggle low", ref_lvl, 16'h0000);
    wait_cnt(16'h0014);
    chk("toggle high", ref_lvl, 16'h0001);
    wr(`TCOC_OFS_MODE, 16'h0000);
    wait_cnt(16'h0014);
    chk("freeze", ref_lvl, 16'h0001);
    // pwm only with preload on, counter above compare when leaving freeze
    wr(`TCOC_OFS_MODE, 16'h0068);
    settle(3);
    chk("freeze to pwm", ref_lvl, 16'h0000);
    wait_cnt(16'h000A);
    chk("pwm1 below", ref_lvl, 16'h0001);
    wait_cnt(16'h001E);
    chk("pwm1 above", ref_lvl, 16'h0000);
    wr(`TCOC_OFS_MODE, 16'h0078);
    wait_cnt(16'h001E);
    chk("pwm2 above", ref_lvl, 16'h0001);
    wait_cnt(16'h000A);
    chk("pwm2 below", ref_lvl, 16'h0000);
    $display("test compare done");
    // compare value out of the counter range, so only the trigger can set the level
    wr(`TCOC_OFS_MODE, 16'h0040);
    wr(`TCOC_OFS_CMP, 16'h00C8);
    wr(`TCOC_OFS_MODE, 16'h0010);
    trig_lat(n0);
    wr(`TCOC_OFS_MODE, 16'h0040);
    wr(`TCOC_OFS_MODE, 16'h0014);
    trig_lat(n1);
    chk("trigger delay gap", 16'(n0 - n1), 16'(`TCOC_TRIG_DLY));
    $display("test trigger done");
    print_verdict();
  end
endmodule : tcoc_channel_tb
